// *** design/keypad_gpio_defs.svh ***
// register offsets, reset values and field positions of the port block
// assumes an 8-bit register address space reached by the serial-bus core
`ifndef KEYPAD_GPIO_DEFS_SVH
`define KEYPAD_GPIO_DEFS_SVH

`define KGP_OFS_DRIVE_MODE 8'h32
`define KGP_OFS_IN_LOW 8'h33
`define KGP_OFS_IN_HIGH 8'h34
`define KGP_OFS_PORT_LEVEL 8'h35
`define KGP_OFS_PORT_BLOCK 8'h36
`define KGP_OFS_MAT_BLOCK_LO 8'h37
`define KGP_OFS_MAT_BLOCK_HI 8'h38

`define KGP_RST_DRIVE_MODE 5'h00
`define KGP_RST_PORT_LEVEL 5'h00
`define KGP_RST_PORT_BLOCK 5'h1f
`define KGP_RST_MAT_BLOCK_LO 8'hff
`define KGP_RST_MAT_BLOCK_HI 7'h7f

`define KGP_PORT_MSB 4
`define KGP_MATRIX_R0_BIT 7
`define KGP_RSV_HI_BIT 7

`endif

// *** design/keypad_gpio_pkg.sv ***
// types used by the port register block; its input sampler uses none of them
// assumes nothing beyond a SystemVerilog compiler
package keypad_gpio_pkg;

    typedef enum logic [2:0]
    {
        SEL_NONE = 3'b000,
        SEL_DRIVE_MODE = 3'b001,
        SEL_IN_LOW = 3'b010,
        SEL_IN_HIGH = 3'b011,
        SEL_PORT_LEVEL = 3'b100,
        SEL_PORT_BLOCK = 3'b101,
        SEL_MAT_BLOCK_LO = 3'b110,
        SEL_MAT_BLOCK_HI = 3'b111
    } reg_sel_t;

    typedef logic [7:0] reg_byte_t;

endpackage

// *** design/pin_sample_if.sv ***
// carrier between the register block and the pin sampler
// assumes both ends run on the one block clock
`timescale 1ns/1ps
`default_nettype none

interface pin_sample_if #(parameter int W = 20);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] changed;

    modport sampler (input raw, output level, output changed);
    modport user (output raw, input level, input changed);
endinterface

`default_nettype wire

// *** design/pin_sampler.sv ***
// registers pin levels and flags any bit that changed since last cycle
// assumes pins are already synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module pin_sampler #(parameter int W = 20)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pins in, sampled levels out
    pin_sample_if.sampler pins
);

    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;
    logic [W-1:0] changed_r;
    logic [W-1:0] changed_nxt;
    logic primed_r;

    initial
    begin
        if (W < 1)
            $error("pin_sampler width must be positive");
    end

    always_comb
    begin
        level_nxt = pins.raw;
        // no change reported before the first real sample
        changed_nxt = primed_r ? (pins.raw ^ level_r) : '0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            level_r <= '0;
            changed_r <= '0;
            primed_r <= 1'b0;
        end
        else
        begin
            level_r <= level_nxt;
            changed_r <= changed_nxt;
            primed_r <= 1'b1;
        end
    end

    assign pins.level = level_r;
    assign pins.changed = changed_r;

endmodule

`default_nettype wire

// *** design/keypad_gpio_port_regs.sv ***
// register logic of the five auxiliary ports and the matrix lines used
// as general inputs; the serial-bus core supplies byte-wide accesses
//
// Overview of operation
// - mode bits 4:0 per port; zero means open-drain; reset clears them
// - mode bit one makes that port drive push-pull
// - mode bits 7:5 reserved, read zero, do nothing
// - low input register: row 0 in bit 7, columns 6..0 below
// - high input register: rows 7..1 in bits 6..0, bit 7 zero
// - port value reads sensed pin levels, write sets output levels
// - port mask bits 4:0; set blocks that port's interrupt
// - low matrix mask: row 0 bit 7, columns below; reset masked
// - high matrix mask: rows 7..1 in bits 6..0, bit 7 reserved
`timescale 1ns/1ps
`default_nettype none
`include "keypad_gpio_defs.svh"

module keypad_gpio_port_regs #(parameter int NPORT = 5)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register access from the serial-bus core
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // direction per port, from the direction register elsewhere
    input wire logic [NPORT-1:0] port_is_output,
    // auxiliary ports, three-signal form
    input wire logic [NPORT-1:0] aux_port_in,
    output logic [NPORT-1:0] aux_port_out,
    output logic [NPORT-1:0] aux_port_oe,
    // matrix lines used as general inputs
    input wire logic [7:0] matrix_r_in,
    input wire logic [6:0] matrix_c_in,
    // one-cycle interrupt request to the core's interrupt logic
    output logic input_irq
);

    localparam int NPIN = NPORT + 15;

    initial
    begin
        if (NPORT != `KGP_PORT_MSB + 1)
            $error("port count must match the register layout");
    end

    ////////////////////////////////////////////////////////////////////
    // address decode

    function automatic keypad_gpio_pkg::reg_sel_t decode(
        input logic [7:0] a);
        keypad_gpio_pkg::reg_sel_t s;
        s = keypad_gpio_pkg::SEL_NONE;
        case (a)
            `KGP_OFS_DRIVE_MODE: s = keypad_gpio_pkg::SEL_DRIVE_MODE;
            `KGP_OFS_IN_LOW: s = keypad_gpio_pkg::SEL_IN_LOW;
            `KGP_OFS_IN_HIGH: s = keypad_gpio_pkg::SEL_IN_HIGH;
            `KGP_OFS_PORT_LEVEL: s = keypad_gpio_pkg::SEL_PORT_LEVEL;
            `KGP_OFS_PORT_BLOCK: s = keypad_gpio_pkg::SEL_PORT_BLOCK;
            `KGP_OFS_MAT_BLOCK_LO: s = keypad_gpio_pkg::SEL_MAT_BLOCK_LO;
            `KGP_OFS_MAT_BLOCK_HI: s = keypad_gpio_pkg::SEL_MAT_BLOCK_HI;
            default: s = keypad_gpio_pkg::SEL_NONE;
        endcase
        return s;
    endfunction

    keypad_gpio_pkg::reg_sel_t sel;
    assign sel = decode(reg_addr);

    ////////////////////////////////////////////////////////////////////
    // pin sampling; bit order: ports, columns 0..6, rows 0..7

    pin_sample_if #(.W(NPIN)) pins ();
    assign pins.raw = {matrix_r_in, matrix_c_in, aux_port_in};

    pin_sampler #(.W(NPIN)) u_sampler
    (
        .clk(clk),
        .arst_n(arst_n),
        .pins(pins)
    );

    logic [NPORT-1:0] port_lvl;
    logic [6:0] col_lvl;
    logic [7:0] row_lvl;
    assign port_lvl = pins.level[NPORT-1:0];
    assign col_lvl = pins.level[NPORT+6:NPORT];
    assign row_lvl = pins.level[NPIN-1:NPORT+7];

    ////////////////////////////////////////////////////////////////////
    // writable registers

    logic [NPORT-1:0] drive_mode_r, drive_mode_nxt;
    logic [NPORT-1:0] out_level_r, out_level_nxt;
    logic [NPORT-1:0] port_block_r, port_block_nxt;
    logic [7:0] mat_block_lo_r, mat_block_lo_nxt;
    logic [6:0] mat_block_hi_r, mat_block_hi_nxt;

    always_comb
    begin
        drive_mode_nxt = drive_mode_r;
        out_level_nxt = out_level_r;
        port_block_nxt = port_block_r;
        mat_block_lo_nxt = mat_block_lo_r;
        mat_block_hi_nxt = mat_block_hi_r;
        if (reg_wr)
        begin
            unique case (sel)
                keypad_gpio_pkg::SEL_DRIVE_MODE:
                    drive_mode_nxt = reg_wdata[NPORT-1:0];
                keypad_gpio_pkg::SEL_PORT_LEVEL:
                    out_level_nxt = reg_wdata[NPORT-1:0];
                keypad_gpio_pkg::SEL_PORT_BLOCK:
                    port_block_nxt = reg_wdata[NPORT-1:0];
                keypad_gpio_pkg::SEL_MAT_BLOCK_LO:
                    mat_block_lo_nxt = reg_wdata;
                keypad_gpio_pkg::SEL_MAT_BLOCK_HI:
                    mat_block_hi_nxt = reg_wdata[6:0];
                // input registers and unmapped offsets take no write
                keypad_gpio_pkg::SEL_IN_LOW,
                keypad_gpio_pkg::SEL_IN_HIGH,
                keypad_gpio_pkg::SEL_NONE:
                    drive_mode_nxt = drive_mode_r;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            drive_mode_r <= `KGP_RST_DRIVE_MODE;
            out_level_r <= `KGP_RST_PORT_LEVEL;
            port_block_r <= `KGP_RST_PORT_BLOCK;
            mat_block_lo_r <= `KGP_RST_MAT_BLOCK_LO;
            mat_block_hi_r <= `KGP_RST_MAT_BLOCK_HI;
        end
        else
        begin
            drive_mode_r <= drive_mode_nxt;
            out_level_r <= out_level_nxt;
            port_block_r <= port_block_nxt;
            mat_block_lo_r <= mat_block_lo_nxt;
            mat_block_hi_r <= mat_block_hi_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, pin drivers and interrupt request

    logic [7:0] rdata_r, rdata_nxt;
    logic [NPORT-1:0] pin_out_r, pin_out_nxt;
    logic [NPORT-1:0] pin_oe_r, pin_oe_nxt;
    logic irq_r, irq_nxt;
    logic [NPIN-1:0] pin_block;

    // mask bits laid out in the same order as the sampled pins
    // rows 7..1 on top, then row 0, columns 6..0 and the ports
    assign pin_block = {mat_block_hi_r, mat_block_lo_r[`KGP_MATRIX_R0_BIT],
                        mat_block_lo_r[6:0], port_block_r};

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd)
        begin
            unique case (sel)
                keypad_gpio_pkg::SEL_DRIVE_MODE:
                    rdata_nxt = {3'h0, drive_mode_r};
                keypad_gpio_pkg::SEL_IN_LOW:
                    rdata_nxt = {row_lvl[0], col_lvl};
                keypad_gpio_pkg::SEL_IN_HIGH:
                    rdata_nxt = {1'b0, row_lvl[7:1]};
                keypad_gpio_pkg::SEL_PORT_LEVEL:
                    rdata_nxt = {3'h0, port_lvl};
                keypad_gpio_pkg::SEL_PORT_BLOCK:
                    rdata_nxt = {3'h0, port_block_r};
                keypad_gpio_pkg::SEL_MAT_BLOCK_LO:
                    rdata_nxt = mat_block_lo_r;
                keypad_gpio_pkg::SEL_MAT_BLOCK_HI:
                    rdata_nxt = {1'b0, mat_block_hi_r};
                keypad_gpio_pkg::SEL_NONE:
                    rdata_nxt = 8'h00;
            endcase
        end
        pin_out_nxt = out_level_r;
        // open-drain only sinks; a high level lets the pin float
        pin_oe_nxt = port_is_output & (drive_mode_r | ~out_level_r);
        irq_nxt = |(pins.changed & ~pin_block);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_r <= 8'h00;
            pin_out_r <= '0;
            pin_oe_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign aux_port_out = pin_out_r;
    assign aux_port_oe = pin_oe_r;
    assign input_irq = irq_r;

endmodule

`default_nettype wire

// *** sim/aux_pin_model.sv ***
// pin model at the far side of the five auxiliary ports
// assumes undriven pins settle to the level the bench puts on board
`timescale 1ns/1ps
`default_nettype none

module aux_pin_model
(
    // drive from the block
    input wire logic [4:0] drive,
    input wire logic [4:0] drive_oe,
    // level of undriven pins
    input wire logic [4:0] board,
    // resolved pin levels
    output logic [4:0] level
);
    // an open-drain high is released, so board decides it
    always_comb level = (drive_oe & drive) | (~drive_oe & board);
endmodule

`default_nettype wire

// *** sim/keypad_gpio_port_regs_props.sv ***
// concurrent checks on the port register block
// assumes one clock domain and the block's own ports only
`timescale 1ns/1ps
`default_nettype none

module keypad_gpio_port_regs_props #(parameter int NPORT = 5)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [NPORT-1:0] aux_port_in,
    input wire logic [NPORT-1:0] aux_port_out,
    input wire logic [7:0] matrix_r_in,
    input wire logic [6:0] matrix_c_in,
    input wire logic input_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire logic [NPORT+14:0] v = {aux_port_in, matrix_r_in, matrix_c_in};
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence wr_at(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h32 ||
        reg_addr > 8'h38) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_port_rsv: assert property (rd_at(8'h32) or rd_at(8'h35) or
        rd_at(8'h36) |=> reg_rdata[7:5] == 3'b000)
        else $error("reserved port bits not zero");
    a_high_rsv: assert property (rd_at(8'h34) or rd_at(8'h38)
        |=> !reg_rdata[7])
        else $error("reserved high bit not zero");
    a_in_low: assert property (rd_at(8'h33) |=> reg_rdata ==
        {$past(matrix_r_in[0], 2), $past(matrix_c_in, 2)})
        else $error("low input value wrong");
    a_in_high: assert property (rd_at(8'h34) |=>
        reg_rdata[6:0] == $past(matrix_r_in[7:1], 2))
        else $error("high input value wrong");
    a_port_read: assert property (rd_at(8'h35) |=>
        reg_rdata[NPORT-1:0] == $past(aux_port_in, 2))
        else $error("port value read wrong");
    a_port_write: assert property (wr_at(8'h35) |-> ##2
        aux_port_out == $past(reg_wdata[NPORT-1:0], 2))
        else $error("port level not driven");
    a_irq_cause: assert property (input_irq |->
        $past(v, 2) != $past(v, 3) || $past(v) != $past(v, 2))
        else $error("interrupt without input change");
endmodule

bind keypad_gpio_port_regs keypad_gpio_port_regs_props #(.NPORT(NPORT))
    i_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .aux_port_in(aux_port_in),
    .aux_port_out(aux_port_out), .matrix_r_in(matrix_r_in),
    .matrix_c_in(matrix_c_in), .input_irq(input_irq));

`default_nettype wire

// *** sim/keypad_gpio_port_regs_bench.sv ***
// register-level test of the port block with a pin model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none

module keypad_gpio_port_regs_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] ra = 8'h00;
    logic [7:0] wd = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [4:0] dir = 5'h00;
    logic [4:0] board = 5'h00;
    logic [4:0] pin, pout, poe;
    logic [7:0] mr = 8'h00;
    logic [6:0] mc = 7'h00;
    logic irq;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    keypad_gpio_port_regs i_keypad_gpio_port_regs (.clk(clk),
        .arst_n(arst_n), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .port_is_output(dir),
        .aux_port_in(pin), .aux_port_out(pout), .aux_port_oe(poe),
        .matrix_r_in(mr), .matrix_c_in(mc), .input_irq(irq));
    aux_pin_model i_aux_pin_model (.drive(pout), .drive_oe(poe),
        .board(board), .level(pin));

    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        ra = a;
        wd = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1;
        ra = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        @(posedge clk);
        #1;
        chk($sformatf("reg_%h", a), e, rdata);
    endtask
    // interrupt is a one-cycle pulse, so every cycle is looked at
    task irq_exp(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            seen = seen | irq;
        end
        chk("input_irq", {7'h00, e}, {7'h00, seen});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        arst_n = 1'b1;
        rc(8'h32, 8'h00);
        rc(8'h37, 8'hff);
        rc(8'h40, 8'h00);
        wreg(8'h32, 8'hff);
        rc(8'h32, 8'h1f);
        wreg(8'h36, 8'hff);
        rc(8'h36, 8'h1f);
        wreg(8'h38, 8'hff);
        rc(8'h38, 8'h7f);
        mr = 8'ha5;
        mc = 7'h3c;
        wreg(8'h33, 8'h00);
        wreg(8'h34, 8'hff);
        rc(8'h33, {mr[0], mc});
        rc(8'h34, {1'b0, mr[7:1]});
        mc = 7'h3d;
        irq_exp(1'b0);
        dir = 5'h1f;
        wreg(8'h35, 8'h15);
        settle;
        rc(8'h35, 8'h15);
        chk("aux_port_out", 8'h15, {3'b000, pout});
        chk("aux_port_oe", 8'h1f, {3'b000, poe});
        wreg(8'h32, 8'h00);
        settle;
        chk("aux_port_oe", 8'h0a, {3'b000, poe});
        rc(8'h35, 8'h00);
        board = 5'h1f;
        settle;
        rc(8'h35, 8'h15);
        dir = 5'h00;
        wreg(8'h36, 8'h1e);
        settle;
        board = 5'h1e;
        irq_exp(1'b1);
        wreg(8'h37, 8'hfe);
        settle;
        mc = 7'h3c;
        irq_exp(1'b1);
        mc = 7'h3e;
        irq_exp(1'b0);
        wreg(8'h38, 8'hfe);
        settle;
        mr = 8'ha7;
        irq_exp(1'b1);
        mr = 8'ha6;
        irq_exp(1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
